// ### logic/acc_pkg.sv
package acc_pkg;
	// Clock mode codes
	localparam logic [1:0] CKM_PIN_SCAN = 2'h0;
	localparam logic [1:0] CKM_PIN_ONE = 2'h1;
	localparam logic [1:0] CKM_SERIAL = 2'h2;
	localparam logic [1:0] CKM_EXT = 2'h3;
	localparam logic [1:0] CKM_RST = CKM_SERIAL;
	// Scan mode codes
	localparam logic [1:0] SCN_TO_N = 2'h0;
	localparam logic [1:0] SCN_FROM_N = 2'h1;
	localparam logic [1:0] SCN_REP = 2'h2;
	// Command byte field positions
	localparam int B_CONV = 7;
	localparam int B_SETUP = 6;
	localparam int B_AVG = 5;
	localparam int B_RESET = 4;
	localparam int F_CK = 4;
	localparam int F_REF = 2;
	localparam int F_DIFF = 0;
	localparam int F_CH = 3;
	localparam int F_SCAN = 1;
	localparam int F_TEMP = 0;
	// Reset values and fixed codes
	localparam logic [7:0] PAIR_RST = 8'h00;
	localparam logic [1:0] NSCAN_RST = 2'h0;
	localparam logic [4:0] REP_STEP = 5'h04;
	localparam logic [3:0] CH_TOP = 4'hf;
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [2:0] BYTE_LAST = 3'h7;
	// Timing: internal oscillator cycles per operation
	localparam int CLK_KHZ = 25000;
	localparam int OSC_KHZ = 4400;
	localparam int CONV_OSC = 16;
	localparam int TEMP_OSC = 32;
	localparam int CONV_CYC = (CONV_OSC * CLK_KHZ + OSC_KHZ - 1) / OSC_KHZ;
	localparam int TEMP_CYC = (TEMP_OSC * CLK_KHZ + OSC_KHZ - 1) / OSC_KHZ;
	localparam logic [7:0] EXT_EDGES = 8'h10;
	localparam int RES_W = 16;
	localparam int FIFO_DEPTH = 16;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CONV = 4'h2,
		ST_WAIT = 4'h4,
		ST_EXT = 4'h8
	} acc_st_t;
endpackage : acc_pkg

// ### logic/acc_ctrl.sv
module acc_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 16
) (
	input wire logic clock, // System clock
	input wire logic sys_rst, // Sync reset
	input wire logic flush, // Drop all entries
	input wire logic in_valid, // Write request
	output logic in_ready, // Space or pop this cycle
	input wire logic [W-1:0] in_data, // Write data
	output logic out_valid, // Not empty
	input wire logic out_ready, // Pop
	output logic [W-1:0] out_data, // Head entry
	output logic full // No free entry
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} acc_fifo_t;
	acc_fifo_t s_ff, nxt_s;
	logic push, pop;

	// Flags and head
	assign full = s_ff.cnt == (AW + 1)'(DEPTH);
	assign out_valid = s_ff.cnt != '0;
	assign in_ready = !full || out_ready;
	assign out_data = s_ff.mem[s_ff.rp];

	// Pointer and count update
	always_comb begin
		nxt_s = s_ff;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			nxt_s.mem[s_ff.wp] = in_data;
			nxt_s.wp = s_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_s.rp = s_ff.rp + 1'b1;
		end
		nxt_s.cnt = s_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		if (flush) begin
			nxt_s.wp = '0;
			nxt_s.rp = '0;
			nxt_s.cnt = '0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	property p_cnt_max;
		@(posedge clock) disable iff (sys_rst) s_ff.cnt <= (AW + 1)'(DEPTH);
	endproperty
	a_cnt_max: assert property (p_cnt_max) else $error("fifo count above depth");
endmodule : acc_fifo

// Contract
// - Sample input on rise, change output on fall
// - Chip select fall starts; command byte MSB first
// - Byte after setup loads addressed pair register
// - Bipolar and temperature results two's complement
// - Setup bits 5:4 select clock mode
// - Mode 00: start pulse runs whole scan
// - Mode 01: each pulse converts one channel
// - Reset into mode 10; command starts scan
// - Mode 11: serial clock times, no scan
// - Modes 00/10: end flag low after scan
// - Mode 01: end flag low per conversion
// - End flag high on falls; always mode 11
// - Single-ended channels always unipolar
// - Pairs even positive, next odd negative
// - Pair bit one selects differential range
// - Unipolar differential negative input gives zero
// - Sixteen results plus temperature, overwrite oldest
// - Four zeros, result, two sub-bits
// - Oldest result after chip select; else zeros
// - Temperature read first; newer replaces unread
// - Oscillator runs in modes 00, 01, 10
// - Start input active low on channel 15
module acc_ctrl (
	input wire logic clock, // System clock
	input wire logic sys_rst, // Sync reset
	input wire logic sclk, // Serial clock pin
	input wire logic cs_n, // Chip select pin
	input wire logic din, // Serial data in pin
	output logic dout, // Serial data out
	output logic dout_oe, // Data out driven
	output logic eoc_n, // End of conversion
	input wire logic conversion_start_n, // Start pin
	output logic adc_start, // Start core, pulse
	output logic [3:0] ain_pos_sel, // Positive mux
	output logic [3:0] ain_neg_sel, // Negative mux
	output logic ain_diff, // Differential input
	output logic ain_temp_sel, // Temperature sensor
	input wire logic [9:0] adc_code, // Core result
	input wire logic [1:0] adc_sub, // Core sub-bits
	input wire logic adc_below, // Positive below negative
	input wire logic [11:0] temp_code, // Sensor result
	output logic osc_en, // Oscillator run
	output logic [1:0] clock_mode, // Clock mode
	output logic [1:0] ref_sel // Reference select
);
	import acc_pkg::*;
	typedef struct packed {
		logic sk1, sk2, sk3, cs1, cs2, cs3, di1, di2, cv1, cv2, cv3;
		logic [6:0] rx;
		logic [2:0] rxn;
		logic ppend, pbip;
		logic [1:0] ckm, refs, nscan, scan;
		logic [7:0] uni, bip;
		logic [3:0] chn;
		logic treq;
		logic [15:0] tx;
		logic [4:0] txn;
		logic [2:0] txb;
		logic eoc_n;
		acc_st_t st;
		logic [3:0] cur, last;
		logic [4:0] rep;
		logic tpend, cpend, top;
		logic [7:0] tmr;
		logic [15:0] tres, pdata;
		logic tval, pval, start, adiff, atemp;
		logic [3:0] apos, aneg;
	} acc_state_t;
	acc_state_t s_ff, nxt_s;
	logic sk_rise, sk_fall, cs_low, cs_fall, cs_rise, cv_fall, cv_rise, pin_md;
	logic byte_done, done, launch, bscan, load, pop, flush;
	logic f_valid, f_full, f_ready, cdiff, cbip;
	logic [7:0] rxb, pdiff;
	logic [15:0] okm, f_data, res;
	logic [9:0] code;
	logic [4:0] fnx, fst;
	logic [3:0] lo, hi;

	function automatic logic [4:0] find_ch(input logic [3:0] a, input logic [3:0] b,
		input logic [15:0] okv);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (4'(i) >= a && 4'(i) <= b && okv[i]) r = {1'b1, 4'(i)};
		end
		return r;
	endfunction : find_ch

	acc_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.flush(flush),
		.in_valid(s_ff.pval),
		.in_ready(f_ready),
		.in_data(s_ff.pdata),
		.out_valid(f_valid),
		.out_ready(pop || (s_ff.pval && f_full)), // Full: oldest dropped
		.out_data(f_data),
		.full(f_full)
	);

	// Edges seen after the two-flop synchronisers
	assign sk_rise = s_ff.sk2 && !s_ff.sk3;
	assign sk_fall = !s_ff.sk2 && s_ff.sk3;
	assign cs_low = !s_ff.cs2;
	assign cs_fall = !s_ff.cs2 && s_ff.cs3;
	assign cs_rise = s_ff.cs2 && !s_ff.cs3;
	assign cv_fall = !s_ff.cv2 && s_ff.cv3;
	assign cv_rise = s_ff.cv2 && !s_ff.cv3;
	assign pin_md = s_ff.ckm == CKM_PIN_SCAN || s_ff.ckm == CKM_PIN_ONE;
	assign rxb = {s_ff.rx, s_ff.di2};
	assign byte_done = cs_low && sk_rise && s_ff.rxn == BYTE_LAST;

	// Usable channels and result format
	always_comb begin
		for (int p = 0; p < 8; p++) begin
			pdiff[p] = s_ff.uni[7-p] || s_ff.bip[7-p];
			okm[2*p] = 1'b1;
			okm[2*p+1] = !pdiff[p];
		end
		if (pin_md) begin
			okm[15] = 1'b0;
			okm[14] = !pdiff[7];
		end
		cdiff = pdiff[s_ff.cur[3:1]];
		cbip = s_ff.bip[3'h7 - s_ff.cur[3:1]] && !s_ff.uni[3'h7 - s_ff.cur[3:1]];
		if (!cdiff) begin
			code = adc_code;
		end else if (cbip) begin
			code = {~adc_code[9], adc_code[8:0]};
		end else if (adc_below) begin
			code = 10'h000;
		end else begin
			code = adc_code;
		end
		res = {4'h0, code, adc_sub};
		fnx = find_ch(s_ff.cur + 4'h1, s_ff.last, okm);
	end

	// Serial port, scan sequencer and end flag
	always_comb begin
		nxt_s = s_ff;
		nxt_s.start = 1'b0;
		nxt_s.pval = s_ff.pval && !f_ready;
		{nxt_s.sk1, nxt_s.sk2, nxt_s.sk3} = {sclk, s_ff.sk1, s_ff.sk2};
		{nxt_s.cs1, nxt_s.cs2, nxt_s.cs3} = {cs_n, s_ff.cs1, s_ff.cs2};
		{nxt_s.di1, nxt_s.di2} = {din, s_ff.di1};
		{nxt_s.cv1, nxt_s.cv2, nxt_s.cv3} = {conversion_start_n, s_ff.cv1, s_ff.cv2};
		launch = 1'b0;
		bscan = 1'b0;
		load = 1'b0;
		pop = 1'b0;
		flush = 1'b0;
		done = 1'b0;
		lo = 4'h0;
		hi = 4'h0;
		fst = 5'h00;
		if (cs_rise) begin
			nxt_s.rxn = 3'h0;
			nxt_s.ppend = 1'b0;
		end
		if (cs_low && sk_rise) begin
			nxt_s.rx = rxb[6:0];
			nxt_s.rxn = s_ff.rxn + 3'h1;
		end
		if (byte_done) begin
			if (s_ff.ppend) begin
				nxt_s.ppend = 1'b0;
				if (s_ff.pbip) nxt_s.bip = rxb;
				else nxt_s.uni = rxb;
			end else if (rxb[B_CONV]) begin
				nxt_s.chn = rxb[F_CH+:4];
				nxt_s.scan = rxb[F_SCAN+:2];
				nxt_s.treq = rxb[F_TEMP];
				bscan = s_ff.ckm == CKM_SERIAL || s_ff.ckm == CKM_EXT;
			end else if (rxb[B_SETUP]) begin
				nxt_s.ckm = rxb[F_CK+:2];
				nxt_s.refs = rxb[F_REF+:2];
				nxt_s.ppend = rxb[F_DIFF+1];
				nxt_s.pbip = rxb[F_DIFF];
			end else if (rxb[B_AVG]) begin
				nxt_s.nscan = rxb[1:0];
			end else if (rxb[B_RESET]) begin
				nxt_s.ckm = CKM_RST;
				nxt_s.uni = PAIR_RST;
				nxt_s.bip = PAIR_RST;
				nxt_s.nscan = NSCAN_RST;
				nxt_s.tval = 1'b0;
				nxt_s.st = ST_IDLE;
				flush = 1'b1;
			end
		end
		// Output word: temperature first, then oldest result, else zeros
		if (cs_fall) begin
			nxt_s.txb = 3'h0;
			nxt_s.eoc_n = 1'b1;
			load = s_ff.txn == 5'h00;
		end else if (cs_low && sk_fall) begin
			nxt_s.txb = s_ff.txb + 3'h1;
			if (s_ff.txb == BYTE_LAST && s_ff.txn <= 5'h01) begin
				load = 1'b1;
			end else begin
				nxt_s.tx = {s_ff.tx[14:0], 1'b0};
				nxt_s.txn = (s_ff.txn != 5'h00) ? s_ff.txn - 5'h01 : 5'h00;
			end
		end
		if (load) begin
			nxt_s.txn = WORD_BITS;
			if (s_ff.tval) begin
				nxt_s.tx = s_ff.tres;
				nxt_s.tval = 1'b0;
			end else if (f_valid) begin
				nxt_s.tx = f_data;
				pop = 1'b1;
			end else begin
				nxt_s.tx = 16'h0000;
				nxt_s.txn = 5'h00;
			end
		end
		if (cv_fall && pin_md) nxt_s.eoc_n = 1'b1;
		case (s_ff.st)
			ST_IDLE: begin
				if (cv_fall && pin_md) bscan = 1'b1;
			end
			ST_CONV: begin
				if (s_ff.tmr != 8'h00) nxt_s.tmr = s_ff.tmr - 8'h01;
				else done = !s_ff.pval || f_ready;
			end
			ST_WAIT: begin
				if (cv_rise) launch = 1'b1;
			end
			ST_EXT: begin
				if (s_ff.tmr == 8'h00) done = !s_ff.pval || f_ready;
				else if (sk_rise) nxt_s.tmr = s_ff.tmr - 8'h01;
			end
			default: begin
				nxt_s.st = ST_IDLE;
			end
		endcase
		if (done) begin
			if (s_ff.top) begin
				nxt_s.tres = {4'h0, temp_code};
				nxt_s.tval = 1'b1;
				nxt_s.tpend = 1'b0;
			end else begin
				nxt_s.pdata = res;
				nxt_s.pval = 1'b1;
				if (s_ff.rep > 5'h01) begin
					nxt_s.rep = s_ff.rep - 5'h01;
				end else begin
					nxt_s.cpend = fnx[4] && s_ff.cur != s_ff.last;
					nxt_s.cur = fnx[3:0];
				end
			end
			if (s_ff.ckm == CKM_EXT) begin
				nxt_s.st = ST_IDLE;
			end else if (nxt_s.tpend || nxt_s.cpend) begin
				if (s_ff.ckm == CKM_PIN_ONE) begin
					nxt_s.st = ST_WAIT;
					nxt_s.eoc_n = 1'b0;
				end else begin
					launch = 1'b1;
				end
			end else begin
				nxt_s.st = ST_IDLE;
				nxt_s.eoc_n = 1'b0;
			end
		end
		// Scan bounds from the conversion byte
		if (bscan) begin
			case (nxt_s.scan)
				SCN_TO_N: begin
					lo = 4'h0;
					hi = nxt_s.chn;
				end
				SCN_FROM_N: begin
					lo = nxt_s.chn;
					hi = CH_TOP;
				end
				default: begin
					lo = nxt_s.chn;
					hi = nxt_s.chn;
				end
			endcase
			if (s_ff.ckm == CKM_EXT) hi = lo;
			fst = find_ch(lo, hi, okm);
			nxt_s.cur = fst[3:0];
			nxt_s.cpend = fst[4];
			nxt_s.last = hi;
			nxt_s.tpend = nxt_s.treq && s_ff.ckm != CKM_EXT;
			nxt_s.rep = 5'h01;
			if (nxt_s.scan == SCN_REP && s_ff.ckm != CKM_EXT) begin
				nxt_s.rep = 5'({3'h0, s_ff.nscan} + 5'h01) * REP_STEP;
			end
			if (s_ff.ckm == CKM_PIN_ONE) nxt_s.st = ST_WAIT;
			else launch = 1'b1;
		end
		if (launch) begin
			if (!(nxt_s.tpend || nxt_s.cpend)) begin
				nxt_s.st = ST_IDLE;
				nxt_s.eoc_n = 1'b0;
			end else begin
				nxt_s.st = (s_ff.ckm == CKM_EXT) ? ST_EXT : ST_CONV;
				nxt_s.top = nxt_s.tpend;
				nxt_s.atemp = nxt_s.tpend;
				nxt_s.apos = nxt_s.cur;
				nxt_s.adiff = pdiff[nxt_s.cur[3:1]];
				nxt_s.aneg = nxt_s.adiff ? {nxt_s.cur[3:1], 1'b1} : nxt_s.cur;
				nxt_s.start = 1'b1;
				nxt_s.tmr = 8'(CONV_CYC);
				if (nxt_s.tpend) nxt_s.tmr = 8'(TEMP_CYC);
				if (s_ff.ckm == CKM_EXT) nxt_s.tmr = EXT_EDGES;
			end
		end
		if (nxt_s.ckm == CKM_EXT) nxt_s.eoc_n = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_ff <= '0;
			s_ff.cs1 <= 1'b1;
			s_ff.cs2 <= 1'b1;
			s_ff.cs3 <= 1'b1;
			s_ff.cv1 <= 1'b1;
			s_ff.cv2 <= 1'b1;
			s_ff.cv3 <= 1'b1;
			s_ff.eoc_n <= 1'b1;
			s_ff.ckm <= CKM_RST;
			s_ff.st <= ST_IDLE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from state
	assign dout = s_ff.tx[15];
	assign dout_oe = !s_ff.cs2;
	assign eoc_n = s_ff.eoc_n;
	assign adc_start = s_ff.start;
	assign ain_pos_sel = s_ff.apos;
	assign ain_neg_sel = s_ff.aneg;
	assign ain_diff = s_ff.adiff;
	assign ain_temp_sel = s_ff.atemp;
	assign osc_en = s_ff.ckm != CKM_EXT;
	assign clock_mode = s_ff.ckm;
	assign ref_sel = s_ff.refs;

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_eoc_ext;
		s_ff.ckm == CKM_EXT |-> s_ff.eoc_n;
	endproperty
	a_eoc_ext: assert property (p_eoc_ext) else $error("end flag low in mode 11");
	property p_eoc_cs;
		cs_fall && s_ff.st == ST_IDLE |=> s_ff.eoc_n;
	endproperty
	a_eoc_cs: assert property (p_eoc_cs) else $error("end flag not raised");
	property p_mode_rst;
		$fell(sys_rst) |-> s_ff.ckm == CKM_SERIAL;
	endproperty
	a_mode_rst: assert property (p_mode_rst) else $error("wrong reset mode");
	property p_dout_edge;
		$changed(s_ff.tx[15]) |-> $past(cs_fall || (cs_low && sk_fall));
	endproperty
	a_dout_edge: assert property (p_dout_edge) else $error("data out moved");
	property p_empty_zero;
		cs_fall && s_ff.txn == 5'h00 && !s_ff.tval && !f_valid |=> s_ff.tx == 16'h0000;
	endproperty
	a_empty_zero: assert property (p_empty_zero) else $error("empty not zero");
	property p_fmt;
		s_ff.pval |-> s_ff.pdata[15:12] == 4'h0;
	endproperty
	a_fmt: assert property (p_fmt) else $error("lead bits not zero");
	property p_uni_neg;
		done && !s_ff.top && cdiff && !cbip && adc_below |=> s_ff.pdata[11:2] == 10'h000;
	endproperty
	a_uni_neg: assert property (p_uni_neg) else $error("negative not zero");
	property p_bip;
		done && !s_ff.top && cdiff && cbip |=> s_ff.pdata[11] == !$past(adc_code[9]);
	endproperty
	a_bip: assert property (p_bip) else $error("bipolar sign wrong");
	property p_setup;
		byte_done && !s_ff.ppend && rxb[7:6] == 2'h1 |=> s_ff.ckm == $past(rxb[5:4]);
	endproperty
	a_setup: assert property (p_setup) else $error("clock mode not taken");
	property p_pair;
		byte_done && s_ff.ppend && !s_ff.pbip |=> s_ff.uni == $past(rxb);
	endproperty
	a_pair: assert property (p_pair) else $error("pair byte lost");
	property p_eoc_one;
		done && s_ff.ckm == CKM_PIN_ONE |=> !s_ff.eoc_n;
	endproperty
	a_eoc_one: assert property (p_eoc_one) else $error("no per-conversion end");
	c_scan: cover property (s_ff.st == ST_CONV ##1 s_ff.st == ST_IDLE);
	c_word: cover property (load && f_valid);
	c_ext: cover property (s_ff.st == ST_EXT ##1 s_ff.pval);
endmodule : acc_ctrl

// ### testbench/acc_master_model.sv
module acc_master_model (
	output logic sclk, // Serial clock
	output logic cs_n, // Chip select
	output logic din, // Data to device
	input wire logic dout, // Data from device
	output logic conversion_start_n // Start pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Half period of the 320 ns serial clock, well under the 10MHz and 4.8MHz ceilings
	localparam int HALF = 160;
	// Idle levels: clock stands low, select and start high
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		conversion_start_n = 1'b1;
	end
	// One framed transfer, MSB first; dout captured late in the high phase
	task automatic shift(input int n, input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		cs_n = 1'b0;
		#(2 * HALF);
		for (int i = n - 1; i >= 0; i--) begin
			din = tx[i];
			#HALF sclk = 1'b1;
			#(HALF - 20) rx = {rx[14:0], dout};
			#20 sclk = 1'b0;
		end
		#HALF cs_n = 1'b1;
		// Released line shows the inverse of its last value
		din = ~din;
		#(2 * HALF);
	endtask : shift
	// Single command byte
	task automatic byte8(input logic [7:0] b);
		logic [15:0] r;
		shift(8, {8'h00, b}, r);
	endtask : byte8
	// Two bytes in one frame, also used to read a result word
	task automatic word16(input logic [15:0] tx, output logic [15:0] rx);
		shift(16, tx, rx);
	endtask : word16
	// Low pulse on the start pin
	task automatic start_pulse();
		conversion_start_n = 1'b0;
		#(2 * HALF) conversion_start_n = 1'b1;
	endtask : start_pulse
endmodule : acc_master_model

// ### testbench/adc_serial_conversion_control_tb_top.sv
module adc_serial_conversion_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import acc_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic sclk, cs_n, din, dout, dout_oe, eoc_n, conversion_start_n, adc_start;
	logic [3:0] ain_pos_sel, ain_neg_sel;
	logic ain_diff, ain_temp_sel, osc_en;
	logic [9:0] adc_code = 10'h000;
	logic [1:0] adc_sub = 2'h0;
	logic adc_below = 1'b0;
	logic [11:0] temp_code = 12'h000;
	logic [1:0] clock_mode, ref_sel;
	logic [15:0] rx;
	logic [3:0] ch;
	int failures = 0;
	int checked = 0;
	int seed = 44;

	// Free-running system clock, 40 ns period
	always #20 clock = ~clock;

	acc_ctrl dut (
		.clock, .sys_rst, .sclk, .cs_n, .din, .dout, .dout_oe, .eoc_n, .conversion_start_n,
		.adc_start, .ain_pos_sel, .ain_neg_sel, .ain_diff, .ain_temp_sel, .adc_code,
		.adc_sub, .adc_below, .temp_code, .osc_en, .clock_mode, .ref_sel
	);

	acc_master_model m (
		.sclk, .cs_n, .din, .dout, .conversion_start_n
	);

	// Verdict and end of run
	task automatic report_and_stop();
		if (failures == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	// Word comparison
	task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_w

	// Flag comparison
	task automatic chk_f(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_f

	// Expected result word: zero code when a unipolar pair reads negative,
	// sign bit flipped to two's complement for a bipolar pair
	function automatic logic [15:0] res_word(input logic [9:0] c, input logic [1:0] s,
		input logic zero, input logic bip);
		logic [9:0] k;
		k = bip ? {~c[9], c[8:0]} : c;
		return zero ? 16'h0000 : {4'h0, k, s};
	endfunction : res_word

	// Drive point just after the rising edge
	task automatic step();
		@(posedge clock);
		#1;
	endtask : step

	// Bounded wait for the end-of-conversion flag to drop
	task automatic wait_low(input int lim);
		int n;
		n = 0;
		while (eoc_n !== 1'b0 && n < lim) begin
			@(posedge clock);
			n++;
		end
		#1;
		chk_f(eoc_n, 1'b0);
	endtask : wait_low

	// Read one word; the select fall lifts the flag and the line is released after
	task automatic rd(input logic [15:0] exp);
		m.word16(16'h0000, rx);
		chk_w(rx, exp);
		chk_f(eoc_n, 1'b1);
		chk_f(dout_oe, 1'b0);
	endtask : rd

	// One single-channel conversion with random core values, then drain the buffer
	task automatic conv(input logic [7:0] cmd, input logic pin, input logic dif,
		input logic below, input logic zero);
		logic [15:0] w;
		step();
		adc_code = 10'($random(seed));
		adc_sub = zero ? 2'h0 : 2'($random(seed));
		adc_below = below;
		temp_code = 12'($random(seed));
		w = res_word(adc_code, adc_sub, zero, dif && !zero);
		m.byte8(cmd);
		if (pin) begin
			m.start_pulse();
		end
		chk_f(eoc_n, 1'b1);
		wait_low(CONV_CYC + TEMP_CYC + 100);
		chk_w({12'h000, ain_pos_sel}, {12'h000, cmd[6:3]});
		chk_f(ain_diff, dif);
		if (dif) begin
			chk_w({12'h000, ain_neg_sel}, {12'h000, cmd[6:3] + 4'h1});
		end
		if (cmd[0]) begin
			rd({4'h0, temp_code});
		end
		rd(w);
		rd(16'h0000);
	endtask : conv

	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		#1;
		sys_rst = 1'b0;
		repeat (4) step();
		chk_f(eoc_n, 1'b1);
		chk_f(dout_oe, 1'b0);
		chk_f(osc_en, 1'b1);
		chk_w({14'h0000, clock_mode}, {14'h0000, CKM_RST});
		// Serial-started conversions on random single-ended channels, some with temperature
		for (int i = 0; i < 4; i++) begin
			ch = 4'($unsigned($random(seed)) % 15);
			conv({1'b1, ch, 2'b11, i[0]}, 1'b0, 1'b0, 1'b0, 1'b0);
		end
		// Every clock mode code through the setup byte
		for (int k = 0; k < 4; k++) begin
			m.byte8({2'b01, 2'(k), 4'h0});
			chk_w({14'h0000, clock_mode}, {14'h0000, 2'(k)});
			chk_f(osc_en, k != 3);
			chk_f(eoc_n, 1'b1);
		end
		// Pin-started conversions in modes 00 and 01
		m.byte8(8'h40);
		conv(8'hae, 1'b1, 1'b0, 1'b0, 1'b0);
		m.byte8(8'h50);
		conv(8'hae, 1'b1, 1'b0, 1'b0, 1'b0);
		// Unipolar pair 0/1 reading negative, then bipolar pair 2/3
		m.word16(16'h6280, rx);
		conv(8'h86, 1'b0, 1'b1, 1'b1, 1'b1);
		m.word16(16'h6340, rx);
		conv(8'h96, 1'b0, 1'b1, 1'b1, 1'b0);
		report_and_stop();
	end

	// Watchdog against a hung handshake
	initial begin
		#1000000;
		failures++;
		report_and_stop();
	end
endmodule : adc_serial_conversion_control_tb_top
